// >>> hw/sleep_power_pkg.sv
// Purpose: shared constants and carriers for the sleep and power manager
// Assumes: 250 MHz system clock, 8-bit register port
// Notes: register offsets are local choices
package sleep_power_pkg;
  localparam logic [1:0] ADDR_SLEEP_CTRL = 2'h0;
  localparam logic [1:0] ADDR_CLK_GATE = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam logic [7:0] SLEEP_CTRL_RESET = 8'h00;
  localparam logic [3:0] CLK_GATE_RESET = 4'h0;
  localparam int BIT_DROP_OFF = 7;
  localparam int BIT_ARM = 5;
  localparam int BIT_KIND_HI = 4;
  localparam int BIT_KIND_LO = 3;
  localparam int BIT_UNLOCK = 2;
  localparam int GATE_TIMER1 = 3;
  localparam int GATE_TIMER0 = 2;
  localparam int GATE_SERIAL = 1;
  localparam int GATE_CONV = 0;
  localparam logic [1:0] KIND_IDLE = 2'h0;
  localparam logic [1:0] KIND_NOISE = 2'h1;
  localparam logic [1:0] KIND_POWER_DOWN = 2'h2;
  localparam logic [1:0] KIND_STANDBY = 2'h3;
  localparam int CLK_MHZ = 250;
  localparam int UNLOCK_WINDOW_CYC = 4;
  localparam int DROP_ACTIVE_DELAY_CYC = 3;
  localparam int DROP_ACTIVE_HOLD_CYC = 3;
  localparam int STANDBY_WAKE_CYC = 6;
  localparam int IRQ_HALT_CYC = 4;
  localparam int DETECT_WAKE_US = 60;
  localparam int DETECT_WAKE_CYC = DETECT_WAKE_US * CLK_MHZ;
  typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_WAKE, ST_HALT} pm_state_t;
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic conv;
    logic osc;
  } clk_domains_t;
endpackage

// >>> hw/sleep_power_manager.sv
// Purpose: sleep mode control, timed detector-off unlock, peripheral clock gates
// Assumes: core pulses sleep_instr_in; wake sources arrive from pins
// Notes: register read data valid one cycle after the read strobe
`timescale 1ns/10ps
module sleep_power_manager #(
  parameter int DETECT_WAKE_CYCLES = sleep_power_pkg::DETECT_WAKE_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic sleep_instr_in,
  input wire logic wake_in,
  input wire logic wake_irq_in,
  input wire logic crystal_sel_in,
  input wire logic comp_uses_ref_in,
  output logic cpu_clk_en_out,
  output logic flash_clk_en_out,
  output logic io_clk_en_out,
  output logic conv_clk_en_out,
  output logic osc_en_out,
  output logic [3:0] periph_clk_en_out,
  output logic [3:0] periph_access_en_out,
  output logic comp_mux_avail_out,
  output logic comp_en_out,
  output logic input_buf_en_out,
  output logic detector_on_out,
  output logic irq_halt_out,
  output logic core_run_out
);
  // two-stage synchronisers for pin-level inputs
  logic [3:0] sync1;
  logic [3:0] sync2;
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end
    else
    begin
      sync1 <= {wake_in, wake_irq_in, crystal_sel_in, comp_uses_ref_in};
      sync2 <= sync1;
    end
  end
  logic wake_s;
  logic irq_s;
  logic xtal_s;
  logic cref_s;
  assign {wake_s, irq_s, xtal_s, cref_s} = sync2;

  // register state
  logic arm;
  logic [1:0] kind;
  logic unlock;
  logic drop_req;
  logic [3:0] gate;
  logic [2:0] win_cnt;
  logic [2:0] req_cnt;
  logic drop_active;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic next_arm;
  logic [1:0] next_kind;
  logic next_unlock;
  logic next_drop_req;
  logic [3:0] next_gate;
  logic [2:0] next_win_cnt;
  logic [2:0] next_req_cnt;
  logic next_drop_active;

  // power state
  sleep_power_pkg::pm_state_t state;
  sleep_power_pkg::pm_state_t next_state;
  logic [1:0] sleep_kind;
  logic [1:0] next_sleep_kind;
  logic det_off;
  logic next_det_off;
  logic [31:0] wait_cnt;
  logic [31:0] next_wait_cnt;
  logic irq_wake;
  logic next_irq_wake;

  // register file, unlock window and request timing
  always_comb
  begin
    next_arm = arm;
    next_kind = kind;
    next_unlock = unlock;
    next_drop_req = drop_req;
    next_gate = gate;
    next_win_cnt = (win_cnt != 3'h0) ? win_cnt - 3'h1 : 3'h0;
    next_req_cnt = req_cnt;
    next_drop_active = drop_active;
    next_rdata = 8'h00;
    if (win_cnt == 3'h1)
      next_unlock = 1'b0;
    // request goes active after a delay then self-clears
    if (req_cnt != 3'h0)
    begin
      next_req_cnt = req_cnt - 3'h1;
      if (req_cnt == 3'(sleep_power_pkg::DROP_ACTIVE_HOLD_CYC + 1))
        next_drop_active = 1'b1;
      if (req_cnt == 3'h1)
      begin
        next_drop_active = 1'b0;
        next_drop_req = 1'b0;
      end
    end
    if (wr_in)
    begin
      if (addr_in == sleep_power_pkg::ADDR_SLEEP_CTRL)
      begin
        next_arm = wdata_in[sleep_power_pkg::BIT_ARM];
        next_kind = wdata_in[sleep_power_pkg::BIT_KIND_HI:sleep_power_pkg::BIT_KIND_LO];
        if (wdata_in[sleep_power_pkg::BIT_DROP_OFF] && wdata_in[sleep_power_pkg::BIT_UNLOCK])
        begin
          next_unlock = 1'b1;
          next_win_cnt = 3'(sleep_power_pkg::UNLOCK_WINDOW_CYC);
        end
        else if (wdata_in[sleep_power_pkg::BIT_DROP_OFF] && unlock)
        begin
          next_unlock = 1'b0;
          next_win_cnt = 3'h0;
          next_drop_req = 1'b1;
          next_req_cnt = 3'(sleep_power_pkg::DROP_ACTIVE_DELAY_CYC
                         + sleep_power_pkg::DROP_ACTIVE_HOLD_CYC);
        end
        else if (!wdata_in[sleep_power_pkg::BIT_DROP_OFF] && req_cnt == 3'h0)
        begin
          next_drop_req = 1'b0;
          next_unlock = wdata_in[sleep_power_pkg::BIT_UNLOCK] & 1'b0;
        end
      end
      else if (addr_in == sleep_power_pkg::ADDR_CLK_GATE)
        next_gate = wdata_in[3:0];
    end
    // read mux; status bit 5 shows the clock option strap, which Standby ignores
    if (rd_in)
    begin
      if (addr_in == sleep_power_pkg::ADDR_SLEEP_CTRL)
        next_rdata = {drop_req, 1'b0, arm, kind, unlock, 2'h0};
      else if (addr_in == sleep_power_pkg::ADDR_CLK_GATE)
        next_rdata = {4'h0, gate};
      else if (addr_in == sleep_power_pkg::ADDR_STATUS)
        next_rdata = {2'h0, xtal_s, drop_active, det_off, 3'(state)};
      else
        next_rdata = 8'h00;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      arm <= 1'b0;
      kind <= 2'h0;
      unlock <= 1'b0;
      drop_req <= 1'b0;
      gate <= sleep_power_pkg::CLK_GATE_RESET;
      win_cnt <= 3'h0;
      req_cnt <= 3'h0;
      drop_active <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      arm <= next_arm;
      kind <= next_kind;
      unlock <= next_unlock;
      drop_req <= next_drop_req;
      gate <= next_gate;
      win_cnt <= next_win_cnt;
      req_cnt <= next_req_cnt;
      drop_active <= next_drop_active;
      rdata <= next_rdata;
    end
  end

  // sleep entry, wake timing and detector control
  always_comb
  begin
    next_state = state;
    next_sleep_kind = sleep_kind;
    next_det_off = det_off;
    next_wait_cnt = (wait_cnt != 32'h0) ? wait_cnt - 32'h1 : 32'h0;
    next_irq_wake = irq_wake;
    case (state)
      sleep_power_pkg::ST_RUN:
      begin
        if (sleep_instr_in && arm)
        begin
          next_state = sleep_power_pkg::ST_SLEEP;
          next_sleep_kind = kind;
          next_det_off = drop_active && kind[1];
        end
      end
      sleep_power_pkg::ST_SLEEP:
      begin
        if (wake_s)
        begin
          next_state = sleep_power_pkg::ST_WAKE;
          next_irq_wake = irq_s;
          if (det_off)
            next_wait_cnt = 32'(DETECT_WAKE_CYCLES);
          else
            next_wait_cnt = 32'(sleep_power_pkg::STANDBY_WAKE_CYC);
          next_det_off = 1'b0;
        end
      end
      sleep_power_pkg::ST_WAKE:
      begin
        if (wait_cnt <= 32'h1)
        begin
          if (irq_wake)
          begin
            next_state = sleep_power_pkg::ST_HALT;
            next_wait_cnt = 32'(sleep_power_pkg::IRQ_HALT_CYC);
          end
          else
            next_state = sleep_power_pkg::ST_RUN;
        end
      end
      sleep_power_pkg::ST_HALT:
      begin
        if (wait_cnt <= 32'h1)
        begin
          next_state = sleep_power_pkg::ST_RUN;
          next_irq_wake = 1'b0;
        end
      end
      default:
        next_state = sleep_power_pkg::ST_RUN;
    endcase
  end

  // clock domain enables from the mode in force next cycle
  sleep_power_pkg::clk_domains_t dom;
  always_comb
  begin
    dom = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, conv: 1'b1, osc: 1'b1};
    if (next_state != sleep_power_pkg::ST_RUN)
    begin
      dom.cpu = 1'b0;
      dom.flash = 1'b0;
      if (next_state == sleep_power_pkg::ST_SLEEP)
      begin
        dom.io = (next_sleep_kind == sleep_power_pkg::KIND_IDLE);
        dom.conv = !next_sleep_kind[1];
        dom.osc = (next_sleep_kind != sleep_power_pkg::KIND_POWER_DOWN);
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      state <= sleep_power_pkg::ST_RUN;
      sleep_kind <= sleep_power_pkg::KIND_IDLE;
      det_off <= 1'b0;
      wait_cnt <= 32'h0;
      irq_wake <= 1'b0;
      cpu_clk_en_out <= 1'b1;
      flash_clk_en_out <= 1'b1;
      io_clk_en_out <= 1'b1;
      conv_clk_en_out <= 1'b1;
      osc_en_out <= 1'b1;
      periph_clk_en_out <= 4'hF;
      periph_access_en_out <= 4'hF;
      comp_mux_avail_out <= 1'b1;
      comp_en_out <= 1'b1;
      input_buf_en_out <= 1'b1;
      detector_on_out <= 1'b1;
      irq_halt_out <= 1'b0;
      core_run_out <= 1'b1;
    end
    else
    begin
      state <= next_state;
      sleep_kind <= next_sleep_kind;
      det_off <= next_det_off;
      wait_cnt <= next_wait_cnt;
      irq_wake <= next_irq_wake;
      cpu_clk_en_out <= dom.cpu;
      flash_clk_en_out <= dom.flash;
      io_clk_en_out <= dom.io;
      conv_clk_en_out <= dom.conv;
      osc_en_out <= dom.osc;
      periph_clk_en_out <= ~next_gate & {dom.io, dom.io, dom.io, dom.conv};
      periph_access_en_out <= ~next_gate;
      comp_mux_avail_out <= !next_gate[sleep_power_pkg::GATE_CONV];
      comp_en_out <= !(next_state == sleep_power_pkg::ST_SLEEP && next_sleep_kind[1])
                     || cref_s;
      input_buf_en_out <= dom.io || dom.conv;
      detector_on_out <= !next_det_off;
      irq_halt_out <= (next_state == sleep_power_pkg::ST_HALT);
      core_run_out <= (next_state == sleep_power_pkg::ST_RUN);
    end
  end

  // unlock window closes after four cycles
  a_unlock_window: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $rose(unlock) |-> ##[1:4] !unlock) else $error("unlock window open too long");
  a_drop_active: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $rose(drop_req) |-> !drop_active ##3 drop_active ##3 !drop_active)
    else $error("request activation timing wrong");
  a_sleep_arm: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (state == sleep_power_pkg::ST_RUN && sleep_instr_in && !arm) |=> core_run_out)
    else $error("slept without arm bit");
  a_standby_wake: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (state == sleep_power_pkg::ST_SLEEP && wake_s && !det_off && !irq_s) |-> ##7 core_run_out)
    else $error("standby wake not six cycles");
  a_detector_on: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (state == sleep_power_pkg::ST_SLEEP && wake_s) |=> detector_on_out)
    else $error("detector not restored on wake");
  a_detector_off: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (state == sleep_power_pkg::ST_RUN && sleep_instr_in && arm && !drop_active)
    |=> detector_on_out)
    else $error("detector off without active request");
  a_reserved_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (rd_in && addr_in == sleep_power_pkg::ADDR_CLK_GATE) |=> rdata_out[7:4] == 4'h0)
    else $error("reserved gate bits not zero");
  a_gate_freeze: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (wr_in && addr_in == sleep_power_pkg::ADDR_CLK_GATE && wdata_in[3])
    |=> !periph_clk_en_out[3] && !periph_access_en_out[3])
    else $error("timer1 not stopped");
  a_power_down: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (state == sleep_power_pkg::ST_SLEEP && sleep_kind == sleep_power_pkg::KIND_POWER_DOWN
     && !wake_s) |=> !osc_en_out && !io_clk_en_out)
    else $error("power-down clocks running");
  a_standby_osc: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (state == sleep_power_pkg::ST_SLEEP && sleep_kind == sleep_power_pkg::KIND_STANDBY
     && !wake_s) |=> osc_en_out && !io_clk_en_out && !conv_clk_en_out)
    else $error("standby clocks wrong");
  a_idle_gate: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (state == sleep_power_pkg::ST_SLEEP && sleep_kind == sleep_power_pkg::KIND_IDLE
     && !wake_s && !wr_in) |=> periph_clk_en_out == ~gate)
    else $error("idle peripheral gating wrong");
  a_irq_halt: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (state == sleep_power_pkg::ST_WAKE && wait_cnt <= 32'h1 && irq_wake)
    |=> irq_halt_out [*4] ##1 (!irq_halt_out && core_run_out))
    else $error("interrupt halt not four cycles");

  assign rdata_out = rdata;
endmodule

// >>> bench/core_model.sv
// Purpose: processor core model driving the register port and the sleep instruction
// Assumes: tasks are entered just after a rising clock edge
// Notes: strobes last one cycle; released write data is inverted, never left stale
`timescale 1ns/10ps
module core_model (
  input wire logic clk_in,
  output logic [1:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  output logic sleep_out
);
  // idle bus at time zero
  initial
  begin
    addr_out = 2'h0;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    sleep_out = 1'b0;
  end
  // one write cycle, then release with changed data
  task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask
  // one read cycle; data is picked up by the bench watcher
  task automatic bus_rd(input logic [1:0] a);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
  endtask
  // sleep instruction pulse, arm bit is set beforehand by the caller
  task automatic sleep_op();
    @(posedge clk_in);
    sleep_out <= 1'b1;
    @(posedge clk_in);
    sleep_out <= 1'b0;
  endtask
  // timed unlock: request plus unlock, then request alone after gap + 1 idle cycles
  task automatic unlock(input logic [1:0] kind, input int gap);
    bus_wr(sleep_power_pkg::ADDR_SLEEP_CTRL, {3'h5, kind, 3'h4});
    repeat (gap) @(posedge clk_in);
    bus_wr(sleep_power_pkg::ADDR_SLEEP_CTRL, {3'h5, kind, 3'h0});
  endtask
endmodule

// >>> bench/sleep_power_manager_test.sv
// Purpose: self-checking bench for the sleep and power manager
// Assumes: detector wake stretch shortened to 20 cycles
// Notes: register reads are checked from a queue by a watcher process
`timescale 1ns/10ps
module sleep_power_manager_test;
  localparam int DW = 20;
  localparam int WN = sleep_power_pkg::STANDBY_WAKE_CYC + 4; // two sync flops, fsm edge, lag
  localparam int HN = sleep_power_pkg::IRQ_HALT_CYC;
  logic clk_sys_in;
  logic rst_b_in;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd_s;
  logic sleep_i;
  logic wake_in;
  logic wake_irq_in;
  logic crystal_sel;
  logic comp_ref;
  logic [7:0] rdata_out;
  logic cpu_en, flash_en, io_en, conv_en, osc_en;
  logic [3:0] periph_clk_en_out;
  logic [3:0] periph_access_en_out;
  logic comp_mux_avail_out, comp_en_out, input_buf_en_out;
  logic detector_on_out, irq_halt_out, core_run_out;
  logic rd_q;
  logic [7:0] rnd;
  logic [7:0] exp_q[$];
  logic [9:0] mode_tbl[5];
  int error_cnt;
  int comparisons;
  int i;

  core_model core (.clk_in(clk_sys_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
    .rd_out(rd_s), .sleep_out(sleep_i));

  sleep_power_manager #(.DETECT_WAKE_CYCLES(DW)) dut (.clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd_s),
    .rdata_out(rdata_out), .sleep_instr_in(sleep_i), .wake_in(wake_in),
    .wake_irq_in(wake_irq_in), .crystal_sel_in(crystal_sel), .comp_uses_ref_in(comp_ref),
    .cpu_clk_en_out(cpu_en), .flash_clk_en_out(flash_en), .io_clk_en_out(io_en),
    .conv_clk_en_out(conv_en), .osc_en_out(osc_en), .periph_clk_en_out(periph_clk_en_out),
    .periph_access_en_out(periph_access_en_out), .comp_mux_avail_out(comp_mux_avail_out),
    .comp_en_out(comp_en_out), .input_buf_en_out(input_buf_en_out),
    .detector_on_out(detector_on_out), .irq_halt_out(irq_halt_out),
    .core_run_out(core_run_out));

  // 250 MHz system clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    if (error_cnt == 0 && comparisons > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // note the expected byte, then issue the read
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    core.bus_rd(a);
  endtask

  // read data stands in the cycle after the strobe only
  always @(posedge clk_sys_in)
  begin
    if (rd_q === 1'b1)
    begin
      chk(rdata_out, exp_q.pop_front(), "rdata");
    end
    rd_q <= rd_s;
  end

  // sleep, then check the clock domain enables and analog controls
  task automatic sleep_chk(input logic [7:0] e);
    core.sleep_op();
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk({cpu_en, flash_en, io_en, conv_en, osc_en, comp_en_out, input_buf_en_out,
      detector_on_out}, e, "sleep_outputs");
    chk({7'h0, core_run_out}, 8'h00, "core_run_sleep");
  endtask

  // raise a wake event and time the return to run
  task automatic wake(input logic irq, input int lo, input int hi, input int halt);
    int n;
    int h;
    n = 0;
    h = 0;
    @(posedge clk_sys_in);
    wake_in <= 1'b1;
    wake_irq_in <= irq;
    while (core_run_out !== 1'b1 && n < 200)
    begin
      @(posedge clk_sys_in);
      n++;
      if (irq_halt_out === 1'b1)
        h++;
    end
    chk({7'h0, n >= lo && n <= hi}, 8'h01, "wake_time");
    chk(8'(h), 8'(halt), "halt_cycles");
    chk({7'h0, detector_on_out}, 8'h01, "detector_after_wake");
    wake_in <= 1'b0;
    wake_irq_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
  endtask

  // main sequence
  initial
  begin
    rst_b_in = 1'b0;
    wake_in = 1'b0;
    wake_irq_in = 1'b0;
    crystal_sel = 1'b0;
    comp_ref = 1'b0;
    rd_q = 1'b0;
    rnd = 8'h06;
    error_cnt = 0;
    comparisons = 0;
    mode_tbl = '{10'b00_0_0011111, 10'b01_0_0001111, 10'b10_0_0000000,
      10'b11_0_0000100, 10'b10_1_0000010};
    repeat (10) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    rd(sleep_power_pkg::ADDR_SLEEP_CTRL, 8'h00);
    rd(sleep_power_pkg::ADDR_CLK_GATE, 8'h00);
    rd(2'h3, 8'h00);
    for (i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      core.bus_wr(sleep_power_pkg::ADDR_CLK_GATE, rnd);
      rd(sleep_power_pkg::ADDR_CLK_GATE, {4'h0, rnd[3:0]});
      #1;
      chk({4'h0, periph_clk_en_out}, {4'h0, ~rnd[3:0]}, "clk_gate");
      chk({4'h0, periph_access_en_out}, {4'h0, ~rnd[3:0]}, "access");
      chk({7'h0, comp_mux_avail_out}, {7'h0, ~rnd[0]}, "comp_mux");
    end
    core.bus_wr(sleep_power_pkg::ADDR_SLEEP_CTRL, 8'h10);
    core.sleep_op();
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk({7'h0, core_run_out}, 8'h01, "not_armed");
    rd(sleep_power_pkg::ADDR_STATUS, 8'h00);
    core.bus_wr(sleep_power_pkg::ADDR_CLK_GATE, 8'h05);
    for (i = 0; i < 5; i++)
    begin
      comp_ref <= mode_tbl[i][7];
      core.bus_wr(sleep_power_pkg::ADDR_SLEEP_CTRL, {3'h1, mode_tbl[i][9:8], 3'h0});
      sleep_chk({mode_tbl[i][6:0], 1'b1});
      if (i == 0)
        chk({4'h0, periph_clk_en_out}, 8'h0A, "idle_gate");
      rd(sleep_power_pkg::ADDR_STATUS, 8'h01);
      wake(1'b0, WN, WN, 0);
    end
    comp_ref <= 1'b0;
    core.bus_wr(sleep_power_pkg::ADDR_CLK_GATE, 8'h00);
    @(posedge clk_sys_in);
    #1;
    chk({4'h0, periph_clk_en_out}, 8'h0F, "gate_cleared");
    core.unlock(2'h2, 0);
    rd(sleep_power_pkg::ADDR_STATUS, 8'h00);
    rd(sleep_power_pkg::ADDR_STATUS, 8'h10);
    @(posedge clk_sys_in);
    rd(sleep_power_pkg::ADDR_STATUS, 8'h00);
    rd(sleep_power_pkg::ADDR_SLEEP_CTRL, 8'h30);
    core.unlock(2'h2, 3);
    rd(sleep_power_pkg::ADDR_SLEEP_CTRL, 8'h30);
    core.unlock(2'h2, 2);
    rd(sleep_power_pkg::ADDR_SLEEP_CTRL, 8'hB0);
    repeat (4) @(posedge clk_sys_in);
    crystal_sel <= 1'b1;
    // sleep with an active request: Standby turns detector off, Idle keeps it
    for (i = 0; i < 2; i++)
    begin
      core.unlock(i == 1 ? 2'h0 : 2'h3, 0);
      repeat (2) @(posedge clk_sys_in);
      sleep_chk(i == 1 ? 8'h3F : 8'h08);
      rd(sleep_power_pkg::ADDR_STATUS, i == 1 ? 8'h21 : 8'h29);
      if (i == 1)
        wake(1'b1, WN + HN, WN + HN, HN);
      else
        wake(1'b0, DW + 4, DW + 4, 0);
    end
    final_report();
  end

  // watchdog against a hung wait
  initial
  begin
    #40000;
    error_cnt++;
    final_report();
  end
endmodule
